// *** dv/sacr_host_model.sv ***
// host model: drives conversion start and serial clock, captures data
`timescale 1ns/1ps
module sacr_host_model (
  // clocking
  input wire clk_in,
  // device pins
  input wire dout_in,
  input wire oe_in,
  output reg cnv_out,
  output reg sclk_out,
  output reg sdi_out
);
  // pull-up holds the line high while the device floats it
  wire line_w = oe_in ? dout_in : 1'b1;
  initial begin
    cnv_out = 1'b0;
    sclk_out = 1'b0;
    sdi_out = 1'b1;
  end
  task start(input cs, input busy);
    begin
      @(posedge clk_in) #1;
      sdi_out = cs;
      cnv_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 sdi_out = 1'b1;
      cnv_out = !busy;
      repeat (40) @(posedge clk_in);
    end
  endtask
  task read(input integer n, output reg [16:0] d);
    integer i;
    begin
      @(posedge clk_in) #1 cnv_out = 1'b0;
      d = 17'h00000;
      for (i = 0; i < n; i = i + 1) begin
        #100 sclk_out = 1'b1;
        d = {d[15:0], line_w};
        #100 sclk_out = 1'b0;
      end
    end
  endtask
  // select dropped and raised again while the conversion still runs
  task reselect;
    begin
      @(posedge clk_in) #1;
      sdi_out = 1'b1;
      cnv_out = 1'b1;
      repeat (4) @(posedge clk_in) #1;
      cnv_out = 1'b0;
      repeat (4) @(posedge clk_in) #1;
      cnv_out = 1'b1;
      repeat (40) @(posedge clk_in);
    end
  endtask
endmodule

// *** dv/sacr_readout_monitor.sv ***
// port assertions for the converter readout block
`timescale 1ns/1ps
module sacr_readout_monitor #(
  parameter CONV_CYC = 24
) (
  // clocking
  input wire core_clk_in,
  input wire rst_in,
  // outputs watched
  input wire serial_data_out,
  input wire serial_data_oe_out,
  input wire cs_mode_out,
  input wire busy_mode_out,
  input wire converting_out,
  input wire acquiring_out
);
  localparam int CL = CONV_CYC - 1;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  property p_conv_float; converting_out && $past(converting_out) |-> !serial_data_oe_out; endproperty
  a_conv_float: assert property (p_conv_float) else $error("driven in conversion");
  property p_start_float; $rose(converting_out) |=> !serial_data_oe_out; endproperty
  a_start_float: assert property (p_start_float) else $error("no float at start");
  property p_conv_len; $rose(converting_out) |-> ##CL converting_out ##1 !converting_out; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length");
  property p_acq_after; $fell(converting_out) |-> acquiring_out; endproperty
  a_acq_after: assert property (p_acq_after) else $error("no acquisition");
  property p_busy; $rose(acquiring_out) ##1 (busy_mode_out && cs_mode_out) |->
    serial_data_oe_out && !serial_data_out;
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit missing");
  property p_no_busy; $rose(acquiring_out) ##1 !busy_mode_out |-> !serial_data_oe_out; endproperty
  a_no_busy: assert property (p_no_busy) else $error("early drive");
  property p_daisy; !cs_mode_out && !$past(cs_mode_out) |-> !serial_data_oe_out; endproperty
  a_daisy: assert property (p_daisy) else $error("daisy drives");
  property p_acq_only; serial_data_oe_out && !converting_out |-> acquiring_out; endproperty
  a_acq_only: assert property (p_acq_only) else $error("drive outside acquisition");
endmodule
bind sacr_readout sacr_readout_monitor #(.CONV_CYC(CONV_CYC)) u_mon (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .serial_data_out(serial_data_out),
  .serial_data_oe_out(serial_data_oe_out), .cs_mode_out(cs_mode_out),
  .busy_mode_out(busy_mode_out), .converting_out(converting_out), .acquiring_out(acquiring_out));

// *** dv/testbench.sv ***
// self-checking bench for the converter readout block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
  reg core_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg sv = 1'b0;
  reg [15:0] sc = 16'h0000;
  wire dout, oe, rdy, csm, bsm, conv, acq, cnv, sclk, sdi;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer i;
  reg [16:0] d;
  reg [15:0] e;
  reg [15:0] exp_q[$];
  sacr_readout uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .conversion_start_pin_in(cnv), .serial_clk_in(sclk), .serial_data_in(sdi),
    .serial_data_out(dout), .serial_data_oe_out(oe), .sample_valid_in(sv),
    .sample_ready_out(rdy), .sample_code_in(sc), .cs_mode_out(csm),
    .busy_mode_out(bsm), .converting_out(conv), .acquiring_out(acq));
  sacr_host_model host (.clk_in(core_clk_in), .dout_in(dout), .oe_in(oe),
    .cnv_out(cnv), .sclk_out(sclk), .sdi_out(sdi));
  task tally_and_finish;
    begin
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task t_fill;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge core_clk_in) #1;
        `CHK(rdy, 1'b1)
        sv = 1'b1;
        sc = 16'h8001 ^ 16'(i * 16'h1F35);
        exp_q.push_back(sc);
      end
      @(posedge core_clk_in) #1;
      `CHK(rdy, 1'b0)
      sc = 16'hFFFF;
      @(posedge core_clk_in) #1 sv = 1'b0;
      $display("fill done");
    end
  endtask
  task frame(input cs, input busy);
    begin
      host.start(cs, busy);
      #1;
      `CHK(csm, cs)
      `CHK(bsm, busy)
      `CHK({conv, acq}, 2'b01)
      `CHK({oe, dout & oe}, {busy & cs, 1'b0})
      e = exp_q.pop_front();
      host.read(busy ? 17 : 16, d);
      `CHK(d, cs ? {1'b0, e} : 17'h0FFFF)
      repeat (5) @(posedge core_clk_in) #1;
      `CHK(oe, 1'b0)
      $display("frame cs=%0d busy=%0d done", cs, busy);
    end
  endtask
  task t_abort;
    begin
      host.start(1'b1, 1'b0);
      e = exp_q.pop_front();
      host.read(5, d);
      `CHK(d[4:0], e[15:11])
      `CHK(oe, 1'b1)
      fork
        host.start(1'b1, 1'b0);
        begin
          repeat (6) @(posedge core_clk_in) #1;
          `CHK(oe, 1'b0)
          `CHK(conv, 1'b1)
        end
      join
      e = exp_q.pop_front();
      host.read(16, d);
      `CHK(d, {1'b0, e})
      $display("abort done");
    end
  endtask
  task t_reselect;
    begin
      host.reselect;
      #1;
      `CHK({conv, acq, bsm}, 3'b010)
      e = exp_q.pop_front();
      host.read(16, d);
      `CHK(d, {1'b0, e})
      $display("reselect done");
    end
  endtask
  initial forever #12.5 core_clk_in = ~core_clk_in;
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge core_clk_in);
    #1 rst_in = 1'b0;
    t_fill;
    frame(1'b1, 1'b0);
    frame(1'b1, 1'b1);
    frame(1'b0, 1'b0);
    t_abort;
    t_reselect;
    while (exp_q.size() > 0) frame(1'b1, 1'b0);
    `CHK(rdy, 1'b1)
    tally_and_finish;
  end
endmodule

// *** logic/sacr_consts.vh ***
// timing, width and mode constants for the converter readout block
`ifndef SACR_CONSTS_VH
`define SACR_CONSTS_VH
`define SACR_RES_BITS 16
`define SACR_CLK_MHZ 40
`define SACR_MIN_CONVERSION_TIME_NS 500
`define SACR_MAX_CONVERSION_TIME_NS 710
`define SACR_MIN_CONVERSION_TIME_CYC ((`SACR_MIN_CONVERSION_TIME_NS * `SACR_CLK_MHZ) / 1000)
`define SACR_MAX_CONVERSION_TIME_CYC ((`SACR_MAX_CONVERSION_TIME_NS * `SACR_CLK_MHZ) / 1000)
`define SACR_CONV_CYC_DEF 24
`define SACR_EDGES_PLAIN 5'h10
`define SACR_EDGES_BUSY 5'h11
`define SACR_FIFO_DEPTH 16
`endif

// *** logic/sacr_fifo.v ***
// synchronous valid/ready fifo holding finished conversion results
`timescale 1ns/1ps
module sacr_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clocking
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign in_ready_out = (count_r != DEPTH[AW:0]);
  assign out_valid_out = (count_r != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (ce_in) begin
      if (push) begin
        mem[wr_ptr_r] <= in_data_in;
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// *** logic/sacr_readout.v ***
// conversion control and serial readout of a 16-bit sar converter
// Behaviour
// - serial input high at conversion-start rise selects chip-select mode
// - serial input low at conversion-start rise selects daisy-chain mode; the code never drives the output in that mode
// - busy option adds one indicator bit ahead of result bits
// - conversion timed by own clock; serial clock only shifts data
// - result read only after conversion ends, during acquisition
// - result is unsigned straight binary 16-bit code
// - after conversion, enter powered-down acquisition with result kept
// - conversion-start rise floats output, samples input, starts conversion
// - conversion completes regardless of later conversion-start level
// - no-busy: conversion-start fall drives the msb
// - remaining bits shift out on serial-clock falling edges
// - no-busy: float after 16th falling edge or conversion-start rise
// - busy: drive low at conversion end, then msb-first data
// - busy: float after 17th falling edge or conversion-start rise
`timescale 1ns/1ps
`include "sacr_consts.vh"
module sacr_readout #(
  parameter RES_BITS = `SACR_RES_BITS,
  parameter CONV_CYC = `SACR_CONV_CYC_DEF,
  parameter FIFO_DEPTH = `SACR_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  // clocking
  input wire core_clk_in,
  input wire rst_in,
  input wire ce_in,
  // converter pins
  input wire conversion_start_pin_in,
  input wire serial_clk_in,
  input wire serial_data_in,
  output wire serial_data_out,
  output wire serial_data_oe_out,
  // sample source from the analog core
  input wire sample_valid_in,
  output wire sample_ready_out,
  input wire [RES_BITS-1:0] sample_code_in,
  // status
  output wire cs_mode_out,
  output wire busy_mode_out,
  output wire converting_out,
  output wire acquiring_out
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_ACQ = 2'b10;
  localparam ST_SHIFT = 2'b11;
  localparam [15:0] CONV_CYC_W = CONV_CYC[15:0];
  localparam [4:0] EDGES_PLAIN = `SACR_EDGES_PLAIN;
  localparam [4:0] EDGES_BUSY = `SACR_EDGES_BUSY;
  localparam NPIN = 3;
  localparam PIN_CNV = 0;
  localparam PIN_SCLK = 1;
  localparam PIN_DIN = 2;

  // raw pins gathered so that one generate loop builds all synchronisers
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_sync;
  reg cnv_d_r;
  reg sclk_d_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg cs_mode_r;
  reg busy_mode_r;
  reg [15:0] conv_cnt_r;
  reg [RES_BITS-1:0] result_r;
  reg [RES_BITS-1:0] shift_r;
  reg [4:0] edge_cnt_r;
  reg dout_r;
  reg oe_r;
  wire cnv_s;
  wire sclk_s;
  wire din_s;
  wire cnv_rise;
  wire cnv_fall;
  wire sclk_fall;
  wire start_conv;
  wire conv_done;
  wire busy_bit;
  wire drive_msb;
  wire shift_edge;
  wire frame_last;
  wire fifo_valid;
  wire [RES_BITS-1:0] fifo_code;
  wire take_sample;
  genvar g;

  // last falling edge of a frame: 16 without the busy bit, 17 with it
  function last_edge;
    input busy;
    input [4:0] cnt;
    begin
      if (busy) begin
        last_edge = (cnt == EDGES_BUSY - 5'h01);
      end else begin
        last_edge = (cnt == EDGES_PLAIN - 5'h01);
      end
    end
  endfunction

  assign pin_raw = {serial_data_in, serial_clk_in, conversion_start_pin_in};
  assign cnv_s = pin_sync[PIN_CNV];
  assign sclk_s = pin_sync[PIN_SCLK];
  assign din_s = pin_sync[PIN_DIN];
  assign cnv_rise = cnv_s & ~cnv_d_r;
  assign cnv_fall = ~cnv_s & cnv_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // a rise while converting is ignored, so the host may reuse the pin as a select
  assign start_conv = cnv_rise & (state_r != ST_CONV);
  // length of conversion counted on core clock only
  assign conv_done = (state_r == ST_CONV) && (conv_cnt_r == CONV_CYC_W - 16'h0001);
  // pin low at conversion end in chip-select mode asks for the busy bit
  assign busy_bit = conv_done & ~cnv_s & cs_mode_r;
  assign drive_msb = (state_r == ST_ACQ) & ~busy_mode_r & cnv_fall & cs_mode_r;
  // a rise ends the frame before any further shift
  assign shift_edge = (state_r == ST_SHIFT) & oe_r & sclk_fall & ~cnv_rise;
  assign frame_last = shift_edge & last_edge(busy_mode_r, edge_cnt_r);
  // a result is taken from the queue only when a conversion really starts
  assign take_sample = ce_in & start_conv & fifo_valid;

  // queue between the analog core and the sampler; ready stalls the core
  sacr_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in(sample_code_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(take_sample),
    .out_data_out(fifo_code)
  );

  // pin synchronisers: first stage read only by the second
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      reg [1:0] sync_r;
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          sync_r <= 2'b00;
        end else if (ce_in) begin
          sync_r <= {sync_r[0], pin_raw[g]};
        end
      end
      assign pin_sync[g] = sync_r[1];
    end
  endgenerate

  // delayed copies for edge detection; reset to the idle low level of both pins
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      cnv_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else if (ce_in) begin
      cnv_d_r <= cnv_s;
      sclk_d_r <= sclk_s;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cnv_rise)
          state_nxt = ST_CONV;
      end
      ST_CONV: begin
        // conversion-start level ignored here until done
        if (conv_done)
          state_nxt = ST_ACQ;
      end
      ST_ACQ: begin
        if (cnv_rise)
          state_nxt = ST_CONV;
        else if (busy_mode_r || cnv_fall)
          state_nxt = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (cnv_rise)
          state_nxt = ST_CONV;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // conversion sequencing, mode latch and result capture
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cs_mode_r <= 1'b1;
      conv_cnt_r <= 16'h0000;
      result_r <= {RES_BITS{1'b0}};
    end else if (ce_in) begin
      state_r <= state_nxt;
      if (start_conv) begin
        // mode latched from the serial input at the rise
        cs_mode_r <= din_s;
        conv_cnt_r <= 16'h0000;
        // straight binary code kept as delivered; last value if queue is empty
        if (fifo_valid) begin
          result_r <= fifo_code;
        end
      end else if (state_r == ST_CONV) begin
        conv_cnt_r <= conv_cnt_r + 16'h0001;
      end
    end
  end

  // level of conversion-start at the end picks the busy option
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      busy_mode_r <= 1'b0;
    end else if (ce_in) begin
      if (conv_done) begin
        busy_mode_r <= ~cnv_s;
      end
    end
  end

  // shifter loaded at conversion end, so a cut frame never leaks into the next one
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      shift_r <= {RES_BITS{1'b0}};
      edge_cnt_r <= 5'h00;
      dout_r <= 1'b0;
    end else if (ce_in) begin
      if (conv_done) begin
        shift_r <= result_r;
        edge_cnt_r <= 5'h00;
        if (busy_bit) begin
          dout_r <= 1'b0;
        end
      end else if (drive_msb) begin
        dout_r <= shift_r[RES_BITS-1];
        shift_r <= {shift_r[RES_BITS-2:0], 1'b0};
      end else if (shift_edge) begin
        edge_cnt_r <= edge_cnt_r + 5'h01;
        if (!frame_last) begin
          dout_r <= shift_r[RES_BITS-1];
          shift_r <= {shift_r[RES_BITS-2:0], 1'b0};
        end
      end
    end
  end

  // output enable: every accepted rise floats the line first, whatever the frame did
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      oe_r <= 1'b0;
    end else if (ce_in) begin
      if (start_conv) begin
        oe_r <= 1'b0;
      end else if (busy_bit) begin
        oe_r <= 1'b1;
      end else if (state_r == ST_CONV) begin
        oe_r <= 1'b0;
      end else if (drive_msb) begin
        oe_r <= 1'b1;
      end else if (frame_last) begin
        oe_r <= 1'b0;
      end
    end
  end

  // pin and mode outputs straight from their flip-flops; converting and acquiring decoded from state_r
  assign serial_data_out = dout_r;
  assign serial_data_oe_out = oe_r;
  assign cs_mode_out = cs_mode_r;
  assign busy_mode_out = busy_mode_r;
  assign converting_out = (state_r == ST_CONV);
  assign acquiring_out = (state_r == ST_ACQ) || (state_r == ST_SHIFT);
endmodule
